//--- verilog/tmr16_pkg.sv
// Shared constants, types and register map of the 16-bit capture/compare timer
package tmr16_pkg;

    // ------------------------------------------------------------
    // Register map (byte wide registers, 4-bit address)
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_CTRL_A = 4'h0;
    localparam logic [3:0] ADR_CTRL_B = 4'h1;
    localparam logic [3:0] ADR_CTRL_C = 4'h2;
    localparam logic [3:0] ADR_FLAGS = 4'h3;
    localparam logic [3:0] ADR_IRQ_EN = 4'h4;
    localparam logic [3:0] ADR_CNT_LO = 4'h5;
    localparam logic [3:0] ADR_CNT_HI = 4'h6;
    localparam logic [3:0] ADR_CAP_LO = 4'h7;
    localparam logic [3:0] ADR_CAP_HI = 4'h8;
    localparam logic [3:0] ADR_CMP_LO = 4'h9;
    localparam logic [3:0] ADR_CMP_STEP = 4'h2;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int CB_EDGE = 6;
    localparam int CC_SRC = 0;
    localparam int FLG_OVF = 0;
    localparam int FLG_CAP = 1;
    localparam logic [7:0] CTRL_B_MASK = 8'h5f;
    localparam logic [7:0] CTRL_C_MASK = 8'h01;

    // ------------------------------------------------------------
    // Waveform modes, top values, clock select, output codes
    // ------------------------------------------------------------
    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CLR_CMP = 4'h4;
    localparam logic [3:0] WGM_CLR_CAP = 4'hc;
    localparam logic [15:0] TOP_8 = 16'h00ff;
    localparam logic [15:0] TOP_9 = 16'h01ff;
    localparam logic [15:0] TOP_10 = 16'h03ff;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PRESC_STEP = 10'h001;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03f;
    localparam logic [9:0] DIV256_MASK = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } tmr16_dir_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmr16_bus_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] cap;
        logic [2:0][15:0] cmp;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_c;
        logic [1:0] flags;
        logic [1:0] irq_en;
        tmr16_dir_e dir;
        logic [2:0] wave;
        logic [2:0] cap_sync;
        logic [2:0] cmp_sync;
        logic [2:0] ext_sync;
        logic [9:0] presc;
        logic [7:0] rdata;
    } tmr16_state_s;

    localparam tmr16_state_s STATE_RST = '{
        cnt: 16'h0000, cap: 16'h0000, cmp: 48'h0, ctrl_a: 8'h00,
        ctrl_b: 8'h00, ctrl_c: 8'h00, flags: 2'h0, irq_en: 2'h0,
        dir: DIR_UP, wave: 3'h0, cap_sync: 3'h0, cmp_sync: 3'h0,
        ext_sync: 3'h0, presc: 10'h000, rdata: 8'h00};

endpackage

//--- verilog/tmr16_top.sv
// 16-bit timer/counter with input capture and three compare outputs
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns

module tmr16_top #(
    parameter bit HAS_CMP_SRC = 1'b1
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // Register port
    input wire tmr16_pkg::tmr16_bus_s I_BUS,
    output logic [7:0] O_RDATA,
    // Event pins
    input wire logic I_CAPTURE_PIN,
    input wire logic I_COMPARATOR_OUTPUT,
    input wire logic I_EXT_COUNT_PIN,
    // Interrupt service
    input wire logic I_OVF_IRQ_ACK,
    input wire logic I_CAP_IRQ_ACK,
    output logic O_OVF_IRQ,
    output logic O_CAPTURE_IRQ,
    // Waveform pins
    output logic [2:0] O_WAVE_OUT,
    output logic [2:0] O_WAVE_OVERRIDE
);

    // ------------------------------------------------------------
    // State and decoded signals
    // ------------------------------------------------------------
    tmr16_pkg::tmr16_state_s st;
    tmr16_pkg::tmr16_state_s next_st;
    logic [3:0] wgm;
    logic [2:0] cs;
    logic [15:0] top;
    logic is_fast, is_phase, cap_top;
    logic tick, at_top, ovf_set, ovf_clr, cap_clr;
    logic [2:0] src_sync;
    logic cap_edge, cap_fire, ext_rise, ext_fall;
    logic [2:0] drive;
    logic [2:0] hit;
    logic [1:0] m;
    logic tgl_ok;
    logic wr_cnt;

    always_comb begin
        next_st = st;
        wgm = {st.ctrl_b[4:3], st.ctrl_a[1:0]};
        cs = st.ctrl_b[2:0];
        m = tmr16_pkg::COM_OFF;
        tgl_ok = 1'b0;
        drive = 3'h0;
        hit = 3'h0;
        ovf_set = 1'b0;
        next_st.rdata = 8'h00;
        wr_cnt = I_BUS.wr && (I_BUS.addr == tmr16_pkg::ADR_CNT_LO ||
                              I_BUS.addr == tmr16_pkg::ADR_CNT_HI);

        // ------------------------------------------------------------
        // Pin synchronisers and edge detectors
        // ------------------------------------------------------------
        next_st.cap_sync = {st.cap_sync[1:0], I_CAPTURE_PIN};
        next_st.cmp_sync = {st.cmp_sync[1:0], I_COMPARATOR_OUTPUT};
        next_st.ext_sync = {st.ext_sync[1:0], I_EXT_COUNT_PIN};
        src_sync = (HAS_CMP_SRC && st.ctrl_c[tmr16_pkg::CC_SRC]) ?
                   st.cmp_sync : st.cap_sync;
        cap_edge = st.ctrl_b[tmr16_pkg::CB_EDGE] ?
                   (src_sync[1] && !src_sync[2]) :
                   (!src_sync[1] && src_sync[2]);
        ext_rise = st.ext_sync[1] && !st.ext_sync[2];
        ext_fall = !st.ext_sync[1] && st.ext_sync[2];

        // ------------------------------------------------------------
        // Waveform mode decode
        // ------------------------------------------------------------
        top = tmr16_pkg::CNT_MAX;
        is_fast = 1'b0;
        is_phase = 1'b0;
        cap_top = 1'b0;
        case (wgm)
            4'h1: begin
                top = tmr16_pkg::TOP_8;
                is_phase = 1'b1;
            end
            4'h2: begin
                top = tmr16_pkg::TOP_9;
                is_phase = 1'b1;
            end
            4'h3: begin
                top = tmr16_pkg::TOP_10;
                is_phase = 1'b1;
            end
            4'h4: top = st.cmp[0];
            4'h5: begin
                top = tmr16_pkg::TOP_8;
                is_fast = 1'b1;
            end
            4'h6: begin
                top = tmr16_pkg::TOP_9;
                is_fast = 1'b1;
            end
            4'h7: begin
                top = tmr16_pkg::TOP_10;
                is_fast = 1'b1;
            end
            4'h8, 4'ha: begin
                top = st.cap;
                is_phase = 1'b1;
                cap_top = 1'b1;
            end
            4'h9, 4'hb: begin
                top = st.cmp[0];
                is_phase = 1'b1;
            end
            4'hc: begin
                top = st.cap;
                cap_top = 1'b1;
            end
            4'he: begin
                top = st.cap;
                is_fast = 1'b1;
                cap_top = 1'b1;
            end
            4'hf: begin
                top = st.cmp[0];
                is_fast = 1'b1;
            end
            default: top = tmr16_pkg::CNT_MAX;
        endcase
        at_top = (st.cnt == top);
        cap_fire = cap_edge && !cap_top;

        // ------------------------------------------------------------
        // Prescaler and clock select
        // ------------------------------------------------------------
        next_st.presc = st.presc + tmr16_pkg::PRESC_STEP;
        case (cs)
            tmr16_pkg::CS_DIV1: tick = 1'b1;
            tmr16_pkg::CS_DIV8:
                tick = (st.presc & tmr16_pkg::DIV8_MASK) == tmr16_pkg::DIV8_MASK;
            tmr16_pkg::CS_DIV64:
                tick = (st.presc & tmr16_pkg::DIV64_MASK) == tmr16_pkg::DIV64_MASK;
            tmr16_pkg::CS_DIV256:
                tick = (st.presc & tmr16_pkg::DIV256_MASK) == tmr16_pkg::DIV256_MASK;
            tmr16_pkg::CS_DIV1024:
                tick = st.presc == tmr16_pkg::DIV1024_MASK;
            tmr16_pkg::CS_EXT_FALL: tick = ext_fall;
            tmr16_pkg::CS_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase

        // ------------------------------------------------------------
        // Counter sequence
        // ------------------------------------------------------------
        if (tick) begin
            if (is_phase) begin
                if (st.dir == tmr16_pkg::DIR_UP) begin
                    if (at_top) begin
                        next_st.dir = tmr16_pkg::DIR_DOWN;
                        next_st.cnt = st.cnt - tmr16_pkg::CNT_ONE;
                    end else begin
                        next_st.cnt = st.cnt + tmr16_pkg::CNT_ONE;
                    end
                end else if (st.cnt == tmr16_pkg::CNT_ZERO) begin
                    next_st.dir = tmr16_pkg::DIR_UP;
                    next_st.cnt = st.cnt + tmr16_pkg::CNT_ONE;
                    ovf_set = 1'b1;
                end else begin
                    next_st.cnt = st.cnt - tmr16_pkg::CNT_ONE;
                end
            end else if (is_fast || wgm == tmr16_pkg::WGM_CLR_CMP ||
                         wgm == tmr16_pkg::WGM_CLR_CAP) begin
                next_st.cnt = at_top ? tmr16_pkg::CNT_ZERO :
                              st.cnt + tmr16_pkg::CNT_ONE;
                ovf_set = is_fast ? at_top : (st.cnt == tmr16_pkg::CNT_MAX);
            end else begin
                next_st.cnt = st.cnt + tmr16_pkg::CNT_ONE;
                ovf_set = (st.cnt == tmr16_pkg::CNT_MAX);
            end
        end
        if (!is_phase) begin
            next_st.dir = tmr16_pkg::DIR_UP;
        end

        // ------------------------------------------------------------
        // Compare output channels
        // ------------------------------------------------------------
        for (int i = 0; i < 3; i++) begin
            m = st.ctrl_a[(7 - 2 * i) -: 2];
            hit[i] = tick && (st.cnt == st.cmp[i]);
            tgl_ok = (i == 0) && wgm[3];
            drive[i] = (m != tmr16_pkg::COM_OFF) &&
                       !((is_fast || is_phase) && m == tmr16_pkg::COM_TOGGLE &&
                         !tgl_ok);
            if (!(is_fast || is_phase)) begin
                if (hit[i]) begin
                    case (m)
                        tmr16_pkg::COM_TOGGLE: next_st.wave[i] = !st.wave[i];
                        tmr16_pkg::COM_CLEAR: next_st.wave[i] = 1'b0;
                        tmr16_pkg::COM_SET: next_st.wave[i] = 1'b1;
                        default: next_st.wave[i] = st.wave[i];
                    endcase
                end
            end else if (m == tmr16_pkg::COM_TOGGLE) begin
                if (hit[i] && tgl_ok) begin
                    next_st.wave[i] = !st.wave[i];
                end
            end else if (m[1]) begin
                if (is_fast) begin
                    if (tick && at_top) begin
                        next_st.wave[i] = (m == tmr16_pkg::COM_CLEAR);
                    end else if (hit[i] && st.cmp[i] != top) begin
                        next_st.wave[i] = (m == tmr16_pkg::COM_SET);
                    end
                end else if (hit[i]) begin
                    next_st.wave[i] = (st.dir == tmr16_pkg::DIR_UP) ?
                                      (m == tmr16_pkg::COM_SET) :
                                      (m == tmr16_pkg::COM_CLEAR);
                end
            end
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        ovf_clr = I_OVF_IRQ_ACK;
        cap_clr = I_CAP_IRQ_ACK;
        if (I_BUS.wr) begin
            case (I_BUS.addr)
                tmr16_pkg::ADR_CTRL_A: next_st.ctrl_a = I_BUS.wdata;
                tmr16_pkg::ADR_CTRL_B:
                    next_st.ctrl_b = I_BUS.wdata & tmr16_pkg::CTRL_B_MASK;
                tmr16_pkg::ADR_CTRL_C:
                    next_st.ctrl_c = HAS_CMP_SRC ?
                                     (I_BUS.wdata & tmr16_pkg::CTRL_C_MASK) : 8'h00;
                tmr16_pkg::ADR_FLAGS: begin
                    ovf_clr = ovf_clr || I_BUS.wdata[tmr16_pkg::FLG_OVF];
                    cap_clr = cap_clr || I_BUS.wdata[tmr16_pkg::FLG_CAP];
                end
                tmr16_pkg::ADR_IRQ_EN: next_st.irq_en = I_BUS.wdata[1:0];
                tmr16_pkg::ADR_CNT_LO:
                    next_st.cnt = {st.cnt[15:8], I_BUS.wdata};
                tmr16_pkg::ADR_CNT_HI:
                    next_st.cnt = {I_BUS.wdata, st.cnt[7:0]};
                tmr16_pkg::ADR_CAP_LO: next_st.cap = {st.cap[15:8], I_BUS.wdata};
                tmr16_pkg::ADR_CAP_HI: next_st.cap = {I_BUS.wdata, st.cap[7:0]};
                default: begin
                    for (int i = 0; i < 3; i++) begin
                        if (I_BUS.addr == tmr16_pkg::ADR_CMP_LO +
                            4'(i * tmr16_pkg::ADR_CMP_STEP)) begin
                            next_st.cmp[i] = {st.cmp[i][15:8], I_BUS.wdata};
                        end
                        if (I_BUS.addr == tmr16_pkg::ADR_CMP_LO +
                            4'(i * tmr16_pkg::ADR_CMP_STEP + 1)) begin
                            next_st.cmp[i] = {I_BUS.wdata, st.cmp[i][7:0]};
                        end
                    end
                end
            endcase
        end

        // ------------------------------------------------------------
        // Capture and flags, a set beats a clear
        // ------------------------------------------------------------
        if (cap_fire) begin
            next_st.cap = st.cnt;
        end
        next_st.flags[tmr16_pkg::FLG_CAP] = cap_fire ||
            (st.flags[tmr16_pkg::FLG_CAP] && !cap_clr);
        next_st.flags[tmr16_pkg::FLG_OVF] = ovf_set ||
            (st.flags[tmr16_pkg::FLG_OVF] && !ovf_clr);

        // ------------------------------------------------------------
        // Register reads, data valid in the next cycle
        // ------------------------------------------------------------
        if (I_BUS.rd) begin
            case (I_BUS.addr)
                tmr16_pkg::ADR_CTRL_A: next_st.rdata = st.ctrl_a;
                tmr16_pkg::ADR_CTRL_B: next_st.rdata = st.ctrl_b;
                tmr16_pkg::ADR_CTRL_C: next_st.rdata = st.ctrl_c;
                tmr16_pkg::ADR_FLAGS: next_st.rdata = {6'h00, st.flags};
                tmr16_pkg::ADR_IRQ_EN: next_st.rdata = {6'h00, st.irq_en};
                tmr16_pkg::ADR_CNT_LO: next_st.rdata = st.cnt[7:0];
                tmr16_pkg::ADR_CNT_HI: next_st.rdata = st.cnt[15:8];
                tmr16_pkg::ADR_CAP_LO: next_st.rdata = st.cap[7:0];
                tmr16_pkg::ADR_CAP_HI: next_st.rdata = st.cap[15:8];
                tmr16_pkg::ADR_CMP_LO: next_st.rdata = st.cmp[0][7:0];
                4'ha: next_st.rdata = st.cmp[0][15:8];
                4'hb: next_st.rdata = st.cmp[1][7:0];
                4'hc: next_st.rdata = st.cmp[1][15:8];
                4'hd: next_st.rdata = st.cmp[2][7:0];
                4'he: next_st.rdata = st.cmp[2][15:8];
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            st <= tmr16_pkg::STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_RDATA = st.rdata;
    assign O_WAVE_OUT = st.wave;
    assign O_WAVE_OVERRIDE = drive;
    assign O_OVF_IRQ = st.flags[tmr16_pkg::FLG_OVF] && st.irq_en[tmr16_pkg::FLG_OVF];
    assign O_CAPTURE_IRQ = st.flags[tmr16_pkg::FLG_CAP] &&
                           st.irq_en[tmr16_pkg::FLG_CAP];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RST);

    sequence seq_ext_rise;
        !I_EXT_COUNT_PIN ##1 I_EXT_COUNT_PIN;
    endsequence
    sequence seq_ext_counted;
        ##2 (cs == tmr16_pkg::CS_EXT_RISE && !is_phase && !at_top && !wr_cnt)
        ##1 (st.cnt == $past(st.cnt) + tmr16_pkg::CNT_ONE);
    endsequence
    chk_ext_count_edge: assert property (
        seq_ext_rise |-> seq_ext_counted or
        (##2 !(cs == tmr16_pkg::CS_EXT_RISE && !is_phase && !at_top && !wr_cnt)))
        else $error("external rising edge not counted");
    chk_capture_copy: assert property (
        cap_fire |=> st.cap == $past(st.cnt))
        else $error("capture register missed the count");
    chk_capture_flag: assert property (
        cap_fire |=> st.flags[tmr16_pkg::FLG_CAP] && st.cap == $past(st.cnt))
        else $error("capture flag not set with capture");
    chk_capture_irq: assert property (
        (cap_fire && st.irq_en[tmr16_pkg::FLG_CAP] && !I_BUS.wr) |=> O_CAPTURE_IRQ)
        else $error("capture request missing");
    chk_capture_off: assert property (
        (cap_top && !I_BUS.wr) |=> $stable(st.cap))
        else $error("capture while capture register is top");
    chk_normal_wrap: assert property (
        (wgm == tmr16_pkg::WGM_NORMAL && tick && st.cnt == tmr16_pkg::CNT_MAX && !wr_cnt)
        |=> st.cnt == tmr16_pkg::CNT_ZERO && st.flags[tmr16_pkg::FLG_OVF])
        else $error("normal mode wrap or overflow flag wrong");
    chk_match_clear: assert property (
        (wgm == tmr16_pkg::WGM_CLR_CMP && tick && st.cnt == st.cmp[0] && !wr_cnt)
        |=> st.cnt == tmr16_pkg::CNT_ZERO)
        else $error("clear on compare A failed");
    chk_stop_hold: assert property (
        (cs == tmr16_pkg::CS_STOP && !wr_cnt) |=> st.cnt == $past(st.cnt))
        else $error("stopped counter moved");
    chk_count_write: assert property (
        (I_BUS.wr && I_BUS.addr == tmr16_pkg::ADR_CNT_LO)
        |=> st.cnt[7:0] == $past(I_BUS.wdata))
        else $error("counter write lost");
    chk_toggle_match: assert property (
        (!(is_fast || is_phase) && st.ctrl_a[7:6] == tmr16_pkg::COM_TOGGLE && hit[0])
        |=> st.wave[0] != $past(st.wave[0]))
        else $error("toggle on match failed");
    chk_fast_top_set: assert property (
        (is_fast && st.ctrl_a[7:6] == tmr16_pkg::COM_CLEAR && tick && at_top)
        |=> st.wave[0])
        else $error("fast mode set at top failed");

endmodule

//--- sim/tmr16_pin_model.sv
// Behavioural model of the capture, comparator and external count pins
`timescale 1ns/1ns
module tmr16_pin_model (
    // Clock
    input wire logic i_clk,
    // Pins: [0] capture, [1] comparator, [2] external count
    output logic [2:0] o_pins
);
    initial o_pins = 3'h0;
    // Each level is held four cycles so the synchroniser sees it
    task drive(input int n, input logic v);
        o_pins[n] <= v;
        repeat (4) @(posedge i_clk);
    endtask
    // Full pulses on the external count pin
    task pulse(input int k);
        repeat (k) begin
            drive(2, 1'b1);
            drive(2, 1'b0);
        end
    endtask
endmodule

//--- sim/tmr16_tb_top.sv
// Self-checking bench of the 16-bit capture/compare timer
`timescale 1ns/1ns
module tmr16_tb_top;
    logic clk;
    logic rst;
    tmr16_pkg::tmr16_bus_s bus;
    logic [7:0] rdata;
    logic [2:0] pins;
    logic ovf_ack;
    logic cap_ack;
    logic ovf_irq;
    logic cap_irq;
    logic [2:0] wave;
    logic [2:0] ovr;
    logic [7:0] q;
    logic [15:0] w;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    tmr16_top DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_BUS(bus), .O_RDATA(rdata),
        .I_CAPTURE_PIN(pins[0]), .I_COMPARATOR_OUTPUT(pins[1]), .I_EXT_COUNT_PIN(pins[2]),
        .I_OVF_IRQ_ACK(ovf_ack), .I_CAP_IRQ_ACK(cap_ack), .O_OVF_IRQ(ovf_irq),
        .O_CAPTURE_IRQ(cap_irq), .O_WAVE_OUT(wave), .O_WAVE_OVERRIDE(ovr));
    tmr16_pin_model pm (.i_clk(clk), .o_pins(pins));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
    task acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: wr, rd: !wr};
        @(posedge clk);
        bus <= '0;
        #1 q = rdata;
        @(posedge clk);
    endtask
    task rd16(input logic [3:0] a);
        acc(1'b0, a, 8'h00);
        w[7:0] = q;
        acc(1'b0, a + 4'h1, 8'h00);
        w[15:8] = q;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task summarize();
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs();
        acc(1'b0, tmr16_pkg::ADR_CTRL_A, 8'h00);
        chk(q, 16'h0000);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'hdf);
        acc(1'b0, tmr16_pkg::ADR_CTRL_B, 8'h00);
        chk(q, 16'h005f);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h00);
        acc(1'b0, 4'hf, 8'h00);
        chk(q, 16'h0000);
    endtask
    task t_cap();
        acc(1'b1, tmr16_pkg::ADR_CNT_HI, 8'h12);
        acc(1'b1, tmr16_pkg::ADR_CNT_LO, 8'h34);
        acc(1'b1, tmr16_pkg::ADR_IRQ_EN, 8'h03);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h40);
        pm.drive(0, 1'b1);
        rd16(tmr16_pkg::ADR_CAP_LO);
        chk(w, 16'h1234);
        chk(cap_irq, 16'h1);
        cap_ack <= 1'b1;
        @(posedge clk);
        cap_ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk(cap_irq, 16'h0);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h00);
        acc(1'b1, tmr16_pkg::ADR_CNT_LO, 8'h56);
        pm.drive(0, 1'b0);
        rd16(tmr16_pkg::ADR_CAP_LO);
        chk(w, 16'h1256);
        acc(1'b1, tmr16_pkg::ADR_CTRL_C, 8'h01);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h40);
        acc(1'b1, tmr16_pkg::ADR_CNT_LO, 8'h78);
        pm.drive(1, 1'b1);
        rd16(tmr16_pkg::ADR_CAP_LO);
        chk(w, 16'h1278);
        acc(1'b1, tmr16_pkg::ADR_CTRL_C, 8'h00);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h58);
        pm.drive(0, 1'b1);
        rd16(tmr16_pkg::ADR_CAP_LO);
        chk(w, 16'h1278);
    endtask
    task t_ovf();
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h01);
        acc(1'b1, tmr16_pkg::ADR_CNT_HI, 8'hff);
        acc(1'b1, tmr16_pkg::ADR_CNT_LO, 8'hf0);
        repeat (30) @(posedge clk);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h00);
        acc(1'b0, tmr16_pkg::ADR_CNT_HI, 8'h00);
        chk(q, 16'h0000);
        chk(ovf_irq, 16'h1);
        ovf_ack <= 1'b1;
        @(posedge clk);
        ovf_ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk(ovf_irq, 16'h0);
        acc(1'b1, tmr16_pkg::ADR_CNT_LO, 8'h00);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h02);
        repeat (62) @(posedge clk);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h00);
        acc(1'b0, tmr16_pkg::ADR_CNT_LO, 8'h00);
        chk(q, 16'h0008);
    endtask
    task t_ext();
        acc(1'b1, tmr16_pkg::ADR_CNT_LO, 8'h00);
        acc(1'b1, tmr16_pkg::ADR_CNT_HI, 8'h00);
        acc(1'b1, 4'h9, 8'h03);
        acc(1'b1, 4'hb, 8'h01);
        acc(1'b1, 4'hd, 8'h02);
        acc(1'b1, tmr16_pkg::ADR_CTRL_A, 8'h6c);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h0f);
        pm.pulse(4);
        acc(1'b0, tmr16_pkg::ADR_CNT_LO, 8'h00);
        chk(q, 16'h0000);
        chk(wave, 16'h5);
        chk(ovr, 16'h7);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h0e);
        pm.pulse(2);
        acc(1'b0, tmr16_pkg::ADR_CNT_LO, 8'h00);
        chk(q, 16'h0002);
    endtask
    task t_pwm();
        acc(1'b1, tmr16_pkg::ADR_CNT_LO, 8'h00);
        acc(1'b1, tmr16_pkg::ADR_CAP_HI, 8'h00);
        acc(1'b1, tmr16_pkg::ADR_CAP_LO, 8'h05);
        acc(1'b1, tmr16_pkg::ADR_CTRL_A, 8'hb6);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h1f);
        pm.pulse(4);
        chk(wave, 16'h6);
        chk(ovr, 16'h3);
        pm.pulse(2);
        chk(wave, 16'h5);
        acc(1'b1, tmr16_pkg::ADR_CTRL_B, 8'h17);
        pm.pulse(4);
        chk(wave, 16'h6);
        pm.pulse(4);
        acc(1'b0, tmr16_pkg::ADR_CNT_LO, 8'h00);
        chk(q, 16'h0002);
        chk(wave, 16'h7);
    endtask

    initial begin
        bus = '0;
        ovf_ack = 1'b0;
        cap_ack = 1'b0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_cap();
        t_ovf();
        t_ext();
        t_pwm();
        summarize();
    end
endmodule
